// ===== hw/swr_pkg.sv
// shared constants, command codes, timing counts and state types of the rom command layer
// What this block does
// - memory clear command erases memory from 220h upward plus mission setup registers.
// - clear acts only while clear enable bit is 1; master arms it first.
// - any other valid memory command before the clear drops the clear enable bit.
// - clear runs about 500 us, cannot abort; bus traffic continues meanwhile.
// - on clear completion memory cleared flag becomes 1, clear enable returns 0.
// - conversion only when no mission runs; result lands at address 211h.
// - conversion lasts about 750 ms, uninterruptible, memory stays reachable meanwhile.
// - device is always slave, only pulls the line low through open drain.
// - line idles high; long lows of 16 or 120 us reset slaves.
// - access order: initialisation, rom command, memory command, data transfer.
// - master reset pulse starts every transaction; device answers with presence pulse.
// - master falling edge starts each bit slot; device samples or drives from it.
// - after presence decode one of seven eight-bit rom commands.
// - read identity sends 64 bits: family code, 48-bit serial, crc.
// - match compares 64 identity bits; exact match proceeds, otherwise wait for reset.
// - skip goes straight to memory command decoding without identity bits.
// - search sends bit, complement, reads master bit, continues only on equality.
// - conditional search joins only when a status flag and its select bit are 1.
// - sole survivor of a search pass stays selected as if matched.
// - high-speed skip sets high speed; only a 480 us reset restores regular.
// - high-speed match receives identity fast; match selects and keeps high speed.
// - device starts at regular speed until a high-speed rom command switches it.
package swr_pkg;
	localparam int CLK_MHZ = 200;
	// rom level command codes
	localparam logic [7:0] ROM_READ_ID = 8'h33;
	localparam logic [7:0] ROM_MATCH = 8'h55;
	localparam logic [7:0] ROM_SKIP = 8'hcc;
	localparam logic [7:0] ROM_SEARCH = 8'hf0;
	localparam logic [7:0] ROM_COND_SEARCH = 8'hec;
	localparam logic [7:0] ROM_HS_SKIP = 8'h3c;
	localparam logic [7:0] ROM_HS_MATCH = 8'h69;
	// memory level command codes
	localparam logic [7:0] MEM_CLEAR = 8'h3c;
	localparam logic [7:0] MEM_CONVERT = 8'h44;
	localparam logic [7:0] MEM_WRITE_SP = 8'h0f;
	localparam logic [7:0] MEM_READ_SP = 8'haa;
	localparam logic [7:0] MEM_COPY_SP = 8'h55;
	localparam logic [7:0] MEM_READ = 8'hf0;
	localparam logic [7:0] MEM_READ_CRC = 8'ha5;
	localparam logic [9:0] ERASE_BASE = 10'h220;
	localparam logic [9:0] TEMP_RESULT_ADDR = 10'h211;
	// slot timing, times in microseconds (conversion in milliseconds)
	localparam int SAMPLE_STD_US = 15;
	localparam int HOLD_STD_US = 30;
	localparam int RESET_STD_US = 120;
	localparam int LONG_RESET_US = 480;
	localparam int PRES_WAIT_STD_US = 30;
	localparam int PRES_LOW_STD_US = 120;
	localparam int SAMPLE_HS_US = 2;
	localparam int HOLD_HS_US = 3;
	localparam int RESET_HS_US = 16;
	localparam int PRES_WAIT_HS_US = 3;
	localparam int PRES_LOW_HS_US = 12;
	localparam int CLEAR_US = 500;
	localparam int CONVERT_MS = 750;
	localparam logic [16:0] SAMPLE_STD_CYC = 17'(SAMPLE_STD_US * CLK_MHZ);
	localparam logic [16:0] HOLD_STD_CYC = 17'(HOLD_STD_US * CLK_MHZ);
	localparam logic [16:0] RESET_STD_CYC = 17'(RESET_STD_US * CLK_MHZ);
	localparam logic [16:0] LONG_RESET_CYC = 17'(LONG_RESET_US * CLK_MHZ);
	localparam logic [16:0] PRES_WAIT_STD_CYC = 17'(PRES_WAIT_STD_US * CLK_MHZ);
	localparam logic [16:0] PRES_LOW_STD_CYC = 17'(PRES_LOW_STD_US * CLK_MHZ);
	localparam logic [16:0] SAMPLE_HS_CYC = 17'(SAMPLE_HS_US * CLK_MHZ);
	localparam logic [16:0] HOLD_HS_CYC = 17'(HOLD_HS_US * CLK_MHZ);
	localparam logic [16:0] RESET_HS_CYC = 17'(RESET_HS_US * CLK_MHZ);
	localparam logic [16:0] PRES_WAIT_HS_CYC = 17'(PRES_WAIT_HS_US * CLK_MHZ);
	localparam logic [16:0] PRES_LOW_HS_CYC = 17'(PRES_LOW_HS_US * CLK_MHZ);
	localparam logic [16:0] CLEAR_CYC = 17'(CLEAR_US * CLK_MHZ);
	localparam logic [27:0] CONVERT_CYC = 28'(CONVERT_MS * 1000 * CLK_MHZ);
	typedef enum logic [1:0] {SL_IDLE, SL_SLOT, SL_WAIT, SL_PRES} swr_slot_state_t;
	typedef enum logic [2:0] {RM_IDLE, RM_ROMCMD, RM_READID, RM_MATCH, RM_SEARCH, RM_MEMCMD,
		RM_DATA} swr_rom_state_t;
endpackage

// ===== hw/swr_slot_if.sv
// bit slot carrier between the rom command logic and the slot engine
`timescale 1ns/10ps
interface swr_slot_if;
	logic high_speed;
	logic tx_drive;
	logic tx_bit;
	logic rx_valid;
	logic rx_bit;
	logic reset_pulse;
	logic long_reset;
	modport slot (input high_speed, tx_drive, tx_bit, output rx_valid, rx_bit, reset_pulse,
		long_reset);
	modport ctrl (output high_speed, tx_drive, tx_bit, input rx_valid, rx_bit, reset_pulse,
		long_reset);
endinterface // swr_slot_if

// ===== hw/swr_slot.sv
// slot engine: falling edge timing, reset detection, presence and open-drain drive
`timescale 1ns/10ps
module swr_slot #(
	parameter logic [16:0] HOLD_STD = swr_pkg::HOLD_STD_CYC,
	parameter logic [16:0] RESET_STD = swr_pkg::RESET_STD_CYC,
	parameter logic [16:0] LONG_RESET = swr_pkg::LONG_RESET_CYC,
	parameter logic [16:0] PRES_WAIT_STD = swr_pkg::PRES_WAIT_STD_CYC,
	parameter logic [16:0] PRES_LOW_STD = swr_pkg::PRES_LOW_STD_CYC
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic line_i,
	output logic line_oe_o,
	swr_slot_if.slot slot_io
);
	import swr_pkg::*;
	swr_slot_state_t state, next_state;
	logic [16:0] cnt, next_cnt, low_cnt, next_low_cnt;
	logic line_q, hs_l, next_hs_l, next_drive, next_rx_valid, next_rx_bit, next_reset_pulse;
	logic next_long;

	function automatic logic [16:0] pick(input logic hs, input logic [16:0] fast,
		input logic [16:0] slow);
		pick = hs ? fast : slow;
	endfunction

	// slot timing is frozen at the falling edge so a speed change mid-slot cannot shear it
	always_comb begin
		next_state = state;
		next_cnt = (cnt == 17'h1ffff) ? cnt : cnt + 17'h00001;
		next_hs_l = hs_l;
		next_drive = line_oe_o;
		next_rx_valid = 1'b0;
		next_rx_bit = slot_io.rx_bit;
		next_reset_pulse = 1'b0;
		next_long = slot_io.long_reset;
		next_low_cnt = line_i ? 17'h00000 : ((low_cnt == LONG_RESET) ? low_cnt : low_cnt + 17'h00001);
		case (state)
			SL_IDLE: begin
				if (line_q && !line_i) begin
					next_state = SL_SLOT;
					next_cnt = 17'h00000;
					next_hs_l = slot_io.high_speed;
					next_drive = slot_io.tx_drive & ~slot_io.tx_bit;
				end
			end
			SL_SLOT: begin
				if (cnt == pick(hs_l, SAMPLE_HS_CYC, SAMPLE_STD_CYC)) begin
					next_rx_valid = 1'b1;
					next_rx_bit = line_i;
				end
				if (cnt == pick(hs_l, HOLD_HS_CYC, HOLD_STD)) next_drive = 1'b0;
				if (line_i && low_cnt >= pick(hs_l, RESET_HS_CYC, RESET_STD)) begin
					next_reset_pulse = 1'b1;
					next_long = (low_cnt >= LONG_RESET);
					next_hs_l = slot_io.high_speed & (low_cnt < LONG_RESET);
					next_state = SL_WAIT;
					next_cnt = 17'h00000;
				end else if (line_i && cnt > pick(hs_l, HOLD_HS_CYC, HOLD_STD)) begin
					next_state = SL_IDLE;
				end
			end
			SL_WAIT: begin
				if (cnt == pick(hs_l, PRES_WAIT_HS_CYC, PRES_WAIT_STD)) begin
					next_state = SL_PRES;
					next_cnt = 17'h00000;
					next_drive = 1'b1;
				end
			end
			SL_PRES: begin
				if (cnt == pick(hs_l, PRES_LOW_HS_CYC, PRES_LOW_STD)) begin
					next_state = SL_IDLE;
					next_drive = 1'b0;
				end
			end
			default: next_state = SL_IDLE;
		endcase
	end

	// line idles high, so the edge detector starts from high
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			state <= SL_IDLE;
			cnt <= 17'h00000;
			low_cnt <= 17'h00000;
			line_q <= 1'b1;
			hs_l <= 1'b0;
			line_oe_o <= 1'b0;
			slot_io.rx_valid <= 1'b0;
			slot_io.rx_bit <= 1'b1;
			slot_io.reset_pulse <= 1'b0;
			slot_io.long_reset <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			low_cnt <= next_low_cnt;
			line_q <= line_i;
			hs_l <= next_hs_l;
			line_oe_o <= next_drive;
			slot_io.rx_valid <= next_rx_valid;
			slot_io.rx_bit <= next_rx_bit;
			slot_io.reset_pulse <= next_reset_pulse;
			slot_io.long_reset <= next_long;
		end
	end
endmodule // swr_slot

// ===== hw/swr_top.sv
// rom command layer top: rom command decode, identity transfer, search and timed operations
`timescale 1ns/10ps
module swr_top #(
	parameter logic [16:0] HOLD_STD = swr_pkg::HOLD_STD_CYC,
	parameter logic [16:0] RESET_STD = swr_pkg::RESET_STD_CYC,
	parameter logic [16:0] LONG_RESET = swr_pkg::LONG_RESET_CYC,
	parameter logic [16:0] PRES_WAIT_STD = swr_pkg::PRES_WAIT_STD_CYC,
	parameter logic [16:0] PRES_LOW_STD = swr_pkg::PRES_LOW_STD_CYC,
	parameter logic [16:0] CLEAR_TIME = swr_pkg::CLEAR_CYC,
	parameter logic [27:0] CONVERT_TIME = swr_pkg::CONVERT_CYC
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic line_i,
	output logic line_o,
	output logic line_oe_o,
	input wire logic [63:0] rom_id_i,
	input wire logic [2:0] status_flags_i,
	input wire logic [2:0] search_select_i,
	input wire logic mission_running_i,
	input wire logic [7:0] temp_sample_i,
	input wire logic arm_clear_i,
	input wire logic memory_cleared_ack_i,
	output logic high_speed_flag_o,
	output logic selected_o,
	output logic mem_cmd_stb_o,
	output logic [7:0] mem_cmd_o,
	output logic clear_enable_bit_o,
	output logic memory_cleared_flag_o,
	output logic clear_busy_o,
	output logic [9:0] erase_base_o,
	output logic convert_busy_o,
	output logic temp_write_o,
	output logic [9:0] temp_addr_o,
	output logic [7:0] temp_data_o
);
	import swr_pkg::*;

	swr_slot_if sif ();

	// protocol state
	swr_rom_state_t state, next_state;
	logic [5:0] bitcnt, next_bitcnt;
	logic [7:0] shreg, next_shreg;
	logic [1:0] phase, next_phase;
	logic miss, next_miss;
	logic hs, next_hs;
	logic hs_prev, next_hs_prev;
	logic fast_match, next_fast_match;
	logic next_selected;
	logic next_mem_cmd_stb;
	logic [7:0] next_mem_cmd;
	logic cmd_clear, cmd_convert, cmd_other;

	// timed operation state
	logic clear_en, next_clear_en;
	logic mem_cleared, next_mem_cleared;
	logic clearing, next_clearing;
	logic [16:0] clr_cnt, next_clr_cnt;
	logic converting, next_converting;
	logic [27:0] conv_cnt, next_conv_cnt;
	logic next_temp_we;
	logic [7:0] next_temp_data;

	logic id_bit;
	logic [7:0] rx_byte;
	logic last_bit;

	// the received byte is shifted in from the top, so the first bit ends up in bit 0
	assign rx_byte = {sif.rx_bit, shreg[7:1]};
	assign id_bit = rom_id_i[bitcnt];
	assign last_bit = (bitcnt == 6'h3f);

	// any valid memory command other than clear, convert included, disarms a pending clear
	function automatic logic other_mem_cmd(input logic [7:0] code);
		other_mem_cmd = (code == MEM_WRITE_SP) || (code == MEM_READ_SP) ||
			(code == MEM_COPY_SP) || (code == MEM_READ) || (code == MEM_READ_CRC) ||
			(code == MEM_CONVERT);
	endfunction

	// stays selected once the rom phase is passed, until the next reset pulse
	function automatic logic is_selected(input swr_rom_state_t s);
		is_selected = (s == RM_MEMCMD) || (s == RM_DATA);
	endfunction

	// the slot engine latches these at the master's falling edge
	assign sif.high_speed = hs;
	assign sif.tx_drive = (state == RM_READID) || ((state == RM_SEARCH) && (phase != 2'h2));
	assign sif.tx_bit = (phase == 2'h1) ? ~id_bit : id_bit;

	swr_slot #(
		.HOLD_STD(HOLD_STD),
		.RESET_STD(RESET_STD),
		.LONG_RESET(LONG_RESET),
		.PRES_WAIT_STD(PRES_WAIT_STD),
		.PRES_LOW_STD(PRES_LOW_STD)
	) u_slot (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.line_i(line_i),
		.line_oe_o(line_oe_o),
		.slot_io(sif.slot)
	);

	// protocol: one slot result per rx_valid pulse, reset pulse overrides everything
	always_comb begin
		next_state = state;
		next_bitcnt = bitcnt;
		next_shreg = shreg;
		next_phase = phase;
		next_miss = miss;
		next_hs = hs;
		next_hs_prev = hs_prev;
		next_fast_match = fast_match;
		next_mem_cmd_stb = 1'b0;
		next_mem_cmd = mem_cmd_o;
		cmd_clear = 1'b0;
		cmd_convert = 1'b0;
		cmd_other = 1'b0;
		if (sif.reset_pulse) begin
			next_state = RM_ROMCMD;
			next_bitcnt = 6'h00;
			next_phase = 2'h0;
			if (sif.long_reset) next_hs = 1'b0;
		end else if (sif.rx_valid) begin
			case (state)
				RM_ROMCMD: begin
					next_shreg = rx_byte;
					next_bitcnt = bitcnt + 6'h01;
					if (bitcnt == 6'h07) begin
						next_bitcnt = 6'h00;
						next_miss = 1'b0;
						next_phase = 2'h0;
						next_fast_match = 1'b0;
						case (rx_byte)
							ROM_READ_ID: next_state = RM_READID;
							ROM_MATCH: next_state = RM_MATCH;
							ROM_SKIP: next_state = RM_MEMCMD;
							ROM_SEARCH: next_state = RM_SEARCH;
							ROM_COND_SEARCH: begin
								// any selected condition that is flagged lets the device join
								if (|(status_flags_i & search_select_i))
									next_state = RM_SEARCH;
								else
									next_state = RM_IDLE;
							end
							ROM_HS_SKIP: begin
								next_hs = 1'b1;
								next_state = RM_MEMCMD;
							end
							ROM_HS_MATCH: begin
								// switch now, identity bits arrive at high speed
								next_hs_prev = hs;
								next_hs = 1'b1;
								next_fast_match = 1'b1;
								next_state = RM_MATCH;
							end
							default: next_state = RM_IDLE;
						endcase
					end
				end
				RM_READID: begin
					next_bitcnt = bitcnt + 6'h01;
					if (last_bit) begin
						next_bitcnt = 6'h00;
						next_state = RM_MEMCMD;
					end
				end
				RM_MATCH: begin
					next_miss = miss | (sif.rx_bit != id_bit);
					next_bitcnt = bitcnt + 6'h01;
					if (last_bit) begin
						next_bitcnt = 6'h00;
						if (miss || (sif.rx_bit != id_bit)) begin
							next_state = RM_IDLE;
							// a failed fast match leaves the speed as it was before
							if (fast_match) next_hs = hs_prev;
						end else begin
							next_state = RM_MEMCMD;
						end
					end
				end
				RM_SEARCH: begin
					case (phase)
						2'h0: next_phase = 2'h1;
						2'h1: next_phase = 2'h2;
						default: begin
							next_phase = 2'h0;
							if (sif.rx_bit != id_bit) begin
								next_state = RM_IDLE;
							end else if (last_bit) begin
								next_bitcnt = 6'h00;
								next_state = RM_MEMCMD;
							end else begin
								next_bitcnt = bitcnt + 6'h01;
							end
						end
					endcase
				end
				RM_MEMCMD: begin
					next_shreg = rx_byte;
					next_bitcnt = bitcnt + 6'h01;
					if (bitcnt == 6'h07) begin
						next_bitcnt = 6'h00;
						next_state = RM_DATA;
						next_mem_cmd_stb = 1'b1;
						next_mem_cmd = rx_byte;
						cmd_clear = (rx_byte == MEM_CLEAR);
						cmd_convert = (rx_byte == MEM_CONVERT);
						cmd_other = other_mem_cmd(rx_byte);
					end
				end
				default: ;
			endcase
		end
		next_selected = is_selected(next_state);
	end

	// the speed flag survives reset pulses unless they are long
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			state <= RM_IDLE;
			bitcnt <= 6'h00;
			shreg <= 8'h00;
			phase <= 2'h0;
			miss <= 1'b0;
			hs <= 1'b0;
			hs_prev <= 1'b0;
			fast_match <= 1'b0;
			selected_o <= 1'b0;
			mem_cmd_stb_o <= 1'b0;
			mem_cmd_o <= 8'h00;
			high_speed_flag_o <= 1'b0;
		end else begin
			state <= next_state;
			bitcnt <= next_bitcnt;
			shreg <= next_shreg;
			phase <= next_phase;
			miss <= next_miss;
			hs <= next_hs;
			hs_prev <= next_hs_prev;
			fast_match <= next_fast_match;
			selected_o <= next_selected;
			mem_cmd_stb_o <= next_mem_cmd_stb;
			mem_cmd_o <= next_mem_cmd;
			high_speed_flag_o <= next_hs;
		end
	end

	// timed operations; reset pulses never reach them, so they cannot be cut short
	always_comb begin
		next_clear_en = clear_en;
		next_mem_cleared = mem_cleared;
		next_clearing = clearing;
		next_clr_cnt = clr_cnt;
		next_converting = converting;
		next_conv_cnt = conv_cnt;
		next_temp_we = 1'b0;
		next_temp_data = temp_data_o;
		if (cmd_other) next_clear_en = 1'b0;
		if (memory_cleared_ack_i) next_mem_cleared = 1'b0;
		if (clearing) begin
			if (clr_cnt == CLEAR_TIME - 17'h00001) begin
				next_clearing = 1'b0;
				next_mem_cleared = 1'b1;
				next_clear_en = 1'b0;
			end else begin
				next_clr_cnt = clr_cnt + 17'h00001;
			end
		end else if (cmd_clear && clear_en) begin
			next_clearing = 1'b1;
			next_clr_cnt = 17'h00000;
		end
		// arming after a finish or a drop in the same cycle still sticks
		if (arm_clear_i) next_clear_en = 1'b1;
		if (converting) begin
			if (conv_cnt == CONVERT_TIME - 28'h0000001) begin
				next_converting = 1'b0;
				next_temp_we = 1'b1;
				next_temp_data = temp_sample_i;
			end else begin
				next_conv_cnt = conv_cnt + 28'h0000001;
			end
		end else if (cmd_convert && !mission_running_i) begin
			next_converting = 1'b1;
			next_conv_cnt = 28'h0000000;
		end
	end

	// status outputs mirror the operation flops
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			clear_en <= 1'b0;
			mem_cleared <= 1'b0;
			clearing <= 1'b0;
			clr_cnt <= 17'h00000;
			converting <= 1'b0;
			conv_cnt <= 28'h0000000;
			temp_write_o <= 1'b0;
			temp_data_o <= 8'h00;
			temp_addr_o <= TEMP_RESULT_ADDR;
			erase_base_o <= ERASE_BASE;
			line_o <= 1'b0;
		end else begin
			clear_en <= next_clear_en;
			mem_cleared <= next_mem_cleared;
			clearing <= next_clearing;
			clr_cnt <= next_clr_cnt;
			converting <= next_converting;
			conv_cnt <= next_conv_cnt;
			temp_write_o <= next_temp_we;
			temp_data_o <= next_temp_data;
			temp_addr_o <= TEMP_RESULT_ADDR;
			erase_base_o <= ERASE_BASE;
			line_o <= 1'b0;
		end
	end

	assign clear_enable_bit_o = clear_en;
	assign memory_cleared_flag_o = mem_cleared;
	assign clear_busy_o = clearing;
	assign convert_busy_o = converting;
endmodule // swr_top

// ===== sim/swr_top_sva.sv
// concurrent checks on the ports of the rom command layer top
`timescale 1ns/10ps
module swr_top_sva
	import swr_pkg::*;
#(
	parameter logic [16:0] RESET_STD = swr_pkg::RESET_STD_CYC,
	parameter logic [16:0] LONG_RESET = swr_pkg::LONG_RESET_CYC,
	parameter logic [16:0] CLEAR_TIME = swr_pkg::CLEAR_CYC
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic line_i,
	input wire logic line_o,
	input wire logic line_oe_o,
	input wire logic arm_clear_i,
	input wire logic mission_running_i,
	input wire logic high_speed_flag_o,
	input wire logic mem_cmd_stb_o,
	input wire logic [7:0] mem_cmd_o,
	input wire logic clear_enable_bit_o,
	input wire logic memory_cleared_flag_o,
	input wire logic clear_busy_o,
	input wire logic convert_busy_o,
	input wire logic temp_write_o,
	input wire logic [9:0] temp_addr_o
);
	logic [16:0] busy_cnt, oe_cnt, low_cnt;
	logic [16:0] next_busy_cnt, next_oe_cnt, next_low_cnt;
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	// run lengths of the clear, of our own pull and of any low on the line
	always_comb begin
		next_busy_cnt = clear_busy_o ? busy_cnt + 17'h1 : 17'h0;
		next_oe_cnt = line_oe_o ? oe_cnt + 17'h1 : 17'h0;
		next_low_cnt = line_i ? 17'h0 : low_cnt + 17'h1;
	end
	// counters only, so a long run costs no unrolled repetition
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			busy_cnt <= 17'h0;
			oe_cnt <= 17'h0;
			low_cnt <= 17'h0;
		end else begin
			busy_cnt <= next_busy_cnt;
			oe_cnt <= next_oe_cnt;
			low_cnt <= next_low_cnt;
		end
	end
	a_line_only_low: assert property (line_o == 1'b0)
		else $error("line pin value not low");
	a_pull_bounded: assert property (oe_cnt < RESET_STD)
		else $error("own pull long enough to reset the bus");
	// the strobe and the start of the clear rise on one edge, so the strobe is not a past value
	a_clear_cause: assert property ($rose(clear_busy_o) |-> mem_cmd_stb_o
		&& $past(clear_enable_bit_o) && mem_cmd_o == MEM_CLEAR)
		else $error("clear started without armed clear code");
	a_clear_length: assert property ($fell(clear_busy_o) |-> busy_cnt == CLEAR_TIME)
		else $error("clear run length wrong");
	a_clear_finish: assert property ($fell(clear_busy_o) && !$past(arm_clear_i) |->
		memory_cleared_flag_o && !clear_enable_bit_o)
		else $error("clear end flags wrong");
	// an arm in the decode cycle itself wins, so only that cycle's arm is excused
	a_other_disarms: assert property (mem_cmd_stb_o && mem_cmd_o == MEM_CONVERT
		&& !$past(arm_clear_i) |-> !clear_enable_bit_o)
		else $error("clear enable kept after other command");
	a_convert_gate: assert property ($rose(convert_busy_o) |-> !$past(mission_running_i)
		&& mem_cmd_stb_o && mem_cmd_o == MEM_CONVERT)
		else $error("conversion started wrongly");
	a_result_write: assert property ($fell(convert_busy_o) |-> ##[0:1] temp_write_o)
		else $error("no result write after conversion");
	a_result_place: assert property (temp_write_o |->
		temp_addr_o == TEMP_RESULT_ADDR && !convert_busy_o)
		else $error("result write misplaced");
	a_slow_after_long: assert property ($rose(line_i) && low_cnt >= LONG_RESET |->
		##[1:4] !high_speed_flag_o)
		else $error("speed not regular after long reset");
endmodule // swr_top_sva

// ===== sim/swr_bus_master.sv
// bus master model pulling the shared line through an open-drain output
`timescale 1ns/10ps
module swr_bus_master #(
	parameter int HOLD_REG = 3100
) (
	input wire logic mclk_i,
	input wire logic dev_pull_i,
	input wire logic hs_i,
	output logic line_o
);
	logic pull_low = 1'b0;
	// wired-AND of both pulls against the pull-up, so the idle line is high
	assign line_o = !(pull_low || dev_pull_i);
	// reset pulse, then a fixed window in which the presence low must show
	task automatic reset_bus(input int n, output logic seen);
		@(negedge mclk_i);
		pull_low = 1'b1;
		repeat (n) @(negedge mclk_i);
		pull_low = 1'b0;
		seen = 1'b0;
		repeat (hs_i ? 3200 : 400) begin
			@(negedge mclk_i);
			if (!line_o) seen = 1'b1;
		end
	endtask
	// a one or a read is a short low; a zero is held past the sample point
	task automatic slot(input logic b, output logic r);
		int s;
		int h;
		s = hs_i ? 400 : 3000;
		h = hs_i ? 700 : HOLD_REG + 100;
		@(negedge mclk_i);
		pull_low = 1'b1;
		for (int i = 1; i <= h; i++) begin
			@(negedge mclk_i);
			if (i == (b ? 4 : s + 60)) pull_low = 1'b0;
			if (i == 40) r = line_o;
		end
	endtask
	// bytes go least significant bit first, one slot each
	task automatic send_byte(input logic [7:0] d);
		logic r;
		for (int i = 0; i < 8; i++) slot(d[i], r);
	endtask
	task automatic read_byte(output logic [7:0] d);
		for (int i = 0; i < 8; i++) slot(1'b1, d[i]);
	endtask
endmodule // swr_bus_master

// ===== sim/swr_top_tb_top.sv
// self-checking bench for the rom command layer top
`timescale 1ns/10ps
module swr_top_tb_top;
	import swr_pkg::*;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic arm_clear_i = 1'b0;
	logic memory_cleared_ack_i = 1'b0;
	logic mission_running_i = 1'b0;
	logic hs_mode = 1'b0;
	logic [63:0] rom_id_i = 64'h5a3c_96e1_0f27_b418; // arbitrary identity value
	logic [2:0] status_flags_i = 3'h0;
	logic [2:0] search_select_i = 3'h0;
	logic [7:0] temp_sample_i = 8'h4b;
	logic line_i, line_o, line_oe_o, high_speed_flag_o, selected_o, mem_cmd_stb_o;
	logic clear_enable_bit_o, memory_cleared_flag_o, clear_busy_o, convert_busy_o, temp_write_o;
	logic [7:0] mem_cmd_o, temp_data_o, id_byte;
	logic [9:0] erase_base_o, temp_addr_o;
	int bad_count = 0;
	int num_checks = 0;
	// hold just past the 3000-cycle sample point keeps regular slots short
	swr_top #(.HOLD_STD(17'h0c1c), .RESET_STD(17'h0fa0), .LONG_RESET(17'h1388),
		.PRES_WAIT_STD(17'h0064), .PRES_LOW_STD(17'h00c8), .CLEAR_TIME(17'h32c8),
		.CONVERT_TIME(28'h00003e8)) swr_top_inst (.mclk_i, .rst_i, .line_i, .line_o,
		.line_oe_o, .rom_id_i, .status_flags_i, .search_select_i, .mission_running_i,
		.temp_sample_i, .arm_clear_i, .memory_cleared_ack_i, .high_speed_flag_o, .selected_o,
		.mem_cmd_stb_o, .mem_cmd_o, .clear_enable_bit_o, .memory_cleared_flag_o, .clear_busy_o,
		.erase_base_o, .convert_busy_o, .temp_write_o, .temp_addr_o, .temp_data_o);
	swr_bus_master #(.HOLD_REG(3100)) swr_bus_master_inst (.mclk_i, .dev_pull_i(line_oe_o),
		.hs_i(hs_mode), .line_o(line_i));
	always #2.5 mclk_i = ~mclk_i;
	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// bounded wait on a design level; running out counts as a mismatch
	task automatic wait_level(ref logic sig, input logic lvl, input int n);
		int i;
		i = 0;
		while (sig !== lvl && i < n) begin
			@(negedge mclk_i);
			i++;
		end
		if (i == n) begin
			bad_count++;
			$display("wrong value wait expected %h seen %h", lvl, sig);
			finish_test();
		end
	endtask
	task automatic bus_reset(input int n);
		logic seen;
		swr_bus_master_inst.reset_bus(n, seen);
		check("presence", seen, 1'b1);
	endtask
	task automatic tx(input logic [7:0] b);
		swr_bus_master_inst.send_byte(b);
	endtask
	task automatic arm();
		arm_clear_i = 1'b1;
		@(negedge mclk_i);
		arm_clear_i = 1'b0;
	endtask
	initial begin
		repeat (2) @(negedge mclk_i);
		rst_i = 1'b0;
		check("speed", high_speed_flag_o, 1'b0);
		check("erase base", erase_base_o, ERASE_BASE);
		repeat (2) @(negedge mclk_i);
		// regular speed: reset, then high-speed skip
		bus_reset(4200);
		tx(ROM_HS_SKIP);
		check("speed up", high_speed_flag_o, 1'b1);
		check("skip selects", selected_o, 1'b1);
		hs_mode = 1'b1;
		// identity family byte at high speed
		bus_reset(3400);
		tx(ROM_READ_ID);
		swr_bus_master_inst.read_byte(id_byte);
		check("identity", id_byte, rom_id_i[7:0]);
		// armed clear; the bus still answers a reset while it runs
		bus_reset(3400);
		arm();
		check("armed", clear_enable_bit_o, 1'b1);
		tx(ROM_SKIP);
		tx(MEM_CLEAR);
		check("clearing", clear_busy_o, 1'b1);
		bus_reset(3400);
		check("clear runs on", clear_busy_o, 1'b1);
		// clear time outlasts the skip, so rom traffic is proven to run beside it
		tx(ROM_SKIP);
		check("skip during clear", selected_o, 1'b1);
		check("still clearing", clear_busy_o, 1'b1);
		// a running mission must block the conversion
		mission_running_i = 1'b1;
		tx(MEM_CONVERT);
		check("convert refused", convert_busy_o, 1'b0);
		mission_running_i = 1'b0;
		wait_level(clear_busy_o, 1'b0, 9000);
		check("cleared flag", memory_cleared_flag_o, 1'b1);
		check("enable dropped", clear_enable_bit_o, 1'b0);
		memory_cleared_ack_i = 1'b1;
		@(negedge mclk_i);
		memory_cleared_ack_i = 1'b0;
		check("flag acked", memory_cleared_flag_o, 1'b0);
		// a conversion after arming disarms the clear and posts its result
		bus_reset(3400);
		arm();
		tx(ROM_SKIP);
		tx(MEM_CONVERT);
		check("disarmed", clear_enable_bit_o, 1'b0);
		check("converting", convert_busy_o, 1'b1);
		check("mem command", mem_cmd_o, MEM_CONVERT);
		// the result is taken when the run ends, not when the command arrives
		temp_sample_i = 8'hc3;
		wait_level(temp_write_o, 1'b1, 1500);
		check("temp addr", temp_addr_o, TEMP_RESULT_ADDR);
		check("temp data", temp_data_o, temp_sample_i);
		// long low returns the device to regular speed
		hs_mode = 1'b0;
		bus_reset(5200);
		check("speed back", high_speed_flag_o, 1'b0);
		check("deselected", selected_o, 1'b0);
		finish_test();
	end
endmodule // swr_top_tb_top
bind swr_top swr_top_sva #(.RESET_STD(RESET_STD), .LONG_RESET(LONG_RESET),
	.CLEAR_TIME(CLEAR_TIME)) swr_top_sva_inst (.mclk_i, .rst_i, .line_i, .line_o, .line_oe_o,
	.arm_clear_i, .mission_running_i, .high_speed_flag_o, .mem_cmd_stb_o, .mem_cmd_o,
	.clear_enable_bit_o, .memory_cleared_flag_o, .clear_busy_o, .convert_busy_o,
	.temp_write_o, .temp_addr_o);
